// *** common/lgar_pkg.sv ***
// constants for the lane gain and aux route register bank
package lgar_pkg;
  localparam logic [7:0] ADDR_AUX_ROUTE = 8'h13;
  localparam logic [7:0] ADDR_USB_GAIN  = 8'h20;
  localparam logic [7:0] ADDR_HOST_GAIN = 8'h21;
  localparam logic [7:0] RESET_VAL      = 8'h00;
  localparam int         SNOOP_OFF_BIT  = 7;
  localparam int         ROUTE_HI_BIT   = 5;
  localparam int         ROUTE_LO_BIT   = 4;
  localparam int         LANES          = 4;
  localparam logic [7:0] AUX_WR_MASK    = 8'hbf;
  localparam logic [7:0] USB_WR_MASK    = 8'hff;
  localparam logic [7:0] HOST_WR_MASK   = 8'h0f;
  localparam logic [1:0] ROUTE_AUTO     = 2'h0;
  localparam logic [1:0] ROUTE_STRAIGHT = 2'h1;
  localparam logic [1:0] ROUTE_CROSSED  = 2'h2;
  localparam logic [1:0] ROUTE_OPEN     = 2'h3;
  localparam logic [3:0] ALL_LANES_OFF  = 4'hf;
endpackage : lgar_pkg

// *** core/lgar_regs.sv ***
// register bank: aux sideband routing, lane off bits, receiver gain selects
//
// Functional notes
// [R1] bit 7 of aux register turns snooping off when set; zero watches traffic.
// [R2] route field 00: sideband connection follows lane_config_hi and orient_swap.
// [R3] route field 01: positive aux to sideband one, negative to sideband two.
// [R4] route field 10: positive aux to sideband two, negative to sideband one.
// [R5] route field 11: aux path to sideband pins fully open.
// [R6] snooping off: lane n disabled when its off bit is one.
// [R7] snooping on: off bits stored but do not steer lanes.
// [R8] gain control clear: usb gain nibbles read back sampled usb straps.
// [R9] gain control set: receiver two gain from written upper nibble.
// [R10] gain control set: receiver one gain from written lower nibble.
// [R11] gain control clear: host gain nibble reads back sampled host straps.
// [R12] gain control set: host receiver gain from written nibble.
// [R13] reset clears aux, usb gain and host gain registers, reserved bits too.
// [R14] gains from straps when gain_sw_control low, from registers when high.
// [R15] snooping on: lanes follow snooped lane count, unused lanes off.
// [R16] reserved bits ignore writes and read zero.
`timescale 1ns/1ps
`default_nettype none

// one gain select: software value or zero-filled strap pair
module lgar_gain_pick #(
  parameter int GW = 4, // gain field width
  parameter int SW = 2  // strap pair width
) (
  input  wire logic          sw_ctrl_i, // high takes the software value
  input  wire logic [GW-1:0] soft_i,    // value written by software
  input  wire logic [SW-1:0] strap_i,   // sampled strap pins
  output logic      [GW-1:0] pick_o     // selected gain
);
  // straps only reach the low gain codes; higher codes need software
  wire [GW-1:0] strap_wide = {{(GW-SW){1'b0}}, strap_i};
  assign pick_o = sw_ctrl_i ? soft_i : strap_wide;
endmodule // lgar_gain_pick

module lgar_regs (
  input  wire logic       core_clk_i,        // register clock, 50 MHz
  input  wire logic       resetn_i,          // async reset, active low
  input  wire logic       wr_en_i,           // register write strobe
  input  wire logic [7:0] addr_i,            // register address
  input  wire logic [7:0] wdata_i,           // write data
  output logic      [7:0] rdata_o,           // read data for addr_i
  input  wire logic       gain_sw_control_i, // gain from registers when high
  input  wire logic       lane_config_hi_i,  // lane configuration high bit
  input  wire logic       orient_swap_i,     // connector orientation swap
  input  wire logic [1:0] usb_gain_straps_i, // sampled usb gain straps
  input  wire logic [1:0] host_gain_straps_i,// sampled host gain straps
  input  wire logic [4:0] snoop_lane_count_i,// snooped lane count
  output logic            snoop_off_o,       // aux snooping stopped
  output logic            auxp_sb1_o,        // aux plus to sideband one
  output logic            auxn_sb2_o,        // aux minus to sideband two
  output logic            auxp_sb2_o,        // aux plus to sideband two
  output logic            auxn_sb1_o,        // aux minus to sideband one
  output logic      [3:0] lane_off_o,        // display lane disables
  output logic      [3:0] rx_one_gain_o,     // far receiver one gain
  output logic      [3:0] rx_two_gain_o,     // far receiver two gain
  output logic      [3:0] host_rx_gain_o     // host side receiver gain
);

  logic [7:0] aux_r, aux_nxt;
  logic [7:0] usb_r, usb_nxt;
  logic [7:0] host_r, host_nxt;
  logic [3:0] lane_off_r, lane_off_nxt;
  logic [3:0] rx1_r, rx1_nxt, rx2_r, rx2_nxt, hrx_r, hrx_nxt;
  logic [3:0] route_r, route_nxt;

  wire wr_aux  = wr_en_i && (addr_i == lgar_pkg::ADDR_AUX_ROUTE);
  wire wr_usb  = wr_en_i && (addr_i == lgar_pkg::ADDR_USB_GAIN);
  wire wr_host = wr_en_i && (addr_i == lgar_pkg::ADDR_HOST_GAIN);

  // writes to reserved bits are dropped by the masks
  assign aux_nxt  = wr_aux ? (wdata_i & lgar_pkg::AUX_WR_MASK) // [R16]
                           : aux_r;
  assign usb_nxt  = wr_usb ? (wdata_i & lgar_pkg::USB_WR_MASK) : usb_r;
  assign host_nxt = wr_host ? (wdata_i & lgar_pkg::HOST_WR_MASK) // [R16]
                            : host_r;

  wire       snoop_off = aux_r[lgar_pkg::SNOOP_OFF_BIT]; // [R1]
  wire [1:0] route_sel = aux_r[lgar_pkg::ROUTE_HI_BIT:lgar_pkg::ROUTE_LO_BIT];
  wire [3:0] sw_lanes  = aux_r[lgar_pkg::LANES-1:0];

  // snooped count of 1, 2 or 4 enables the low lanes; others shut all off
  logic [3:0] snoop_lanes_off;
  always_comb begin
    case (snoop_lane_count_i)
      5'h01:   snoop_lanes_off = 4'he;
      5'h02:   snoop_lanes_off = 4'hc;
      5'h04:   snoop_lanes_off = 4'h0;
      default: snoop_lanes_off = lgar_pkg::ALL_LANES_OFF;
    endcase
  end

  // off bits only steer lanes with snooping off; stored regardless
  assign lane_off_nxt = snoop_off ? sw_lanes         // [R6] [R7]
                                  : snoop_lanes_off; // [R15]

  // strap pairs widen into the nibble by zero fill
  wire [3:0] usb_strap_n  = {2'h0, usb_gain_straps_i};
  wire [3:0] host_strap_n = {2'h0, host_gain_straps_i};
  // stored values survive while straps rule, so software need not rewrite
  lgar_gain_pick #(.GW(4), .SW(2)) u_rx1_pick ( // [R10] [R14]
    .sw_ctrl_i (gain_sw_control_i),
    .soft_i    (usb_r[3:0]),
    .strap_i   (usb_gain_straps_i),
    .pick_o    (rx1_nxt)
  );
  lgar_gain_pick #(.GW(4), .SW(2)) u_rx2_pick ( // [R9] [R14]
    .sw_ctrl_i (gain_sw_control_i),
    .soft_i    (usb_r[7:4]),
    .strap_i   (usb_gain_straps_i),
    .pick_o    (rx2_nxt)
  );
  lgar_gain_pick #(.GW(4), .SW(2)) u_hrx_pick ( // [R12] [R14]
    .sw_ctrl_i (gain_sw_control_i),
    .soft_i    (host_r[3:0]),
    .strap_i   (host_gain_straps_i),
    .pick_o    (hrx_nxt)
  );

  // route bits: {auxp_sb1, auxn_sb2, auxp_sb2, auxn_sb1}
  logic [3:0] auto_route;
  always_comb begin
    if (!lane_config_hi_i)
      auto_route = 4'h0;
    else if (orient_swap_i)
      auto_route = 4'h3;
    else
      auto_route = 4'hc;
  end

  always_comb begin
    case (route_sel)
      lgar_pkg::ROUTE_AUTO:     route_nxt = auto_route; // [R2]
      lgar_pkg::ROUTE_STRAIGHT: route_nxt = 4'hc;       // [R3]
      lgar_pkg::ROUTE_CROSSED:  route_nxt = 4'h3;       // [R4]
      lgar_pkg::ROUTE_OPEN:     route_nxt = 4'h0;       // [R5]
      default:                  route_nxt = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aux_r  <= lgar_pkg::RESET_VAL; // [R13]
      usb_r  <= lgar_pkg::RESET_VAL; // [R13]
      host_r <= lgar_pkg::RESET_VAL; // [R13]
    end else begin
      aux_r  <= aux_nxt;
      usb_r  <= usb_nxt;
      host_r <= host_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_off_r <= 4'h0;
      rx1_r      <= 4'h0;
      rx2_r      <= 4'h0;
      hrx_r      <= 4'h0;
      route_r    <= 4'h0;
    end else begin
      lane_off_r <= lane_off_nxt;
      rx1_r      <= rx1_nxt;
      rx2_r      <= rx2_nxt;
      hrx_r      <= hrx_nxt;
      route_r    <= route_nxt;
    end
  end

  // read view: gain fields show the live selection, straps or software
  wire [7:0] usb_view  = {rx2_nxt, rx1_nxt};          // [R8]
  wire [7:0] host_view = {4'h0, hrx_nxt};             // [R11] [R16]
  assign rdata_o = (addr_i == lgar_pkg::ADDR_AUX_ROUTE) ? aux_r :
                   (addr_i == lgar_pkg::ADDR_USB_GAIN)  ? usb_view :
                   (addr_i == lgar_pkg::ADDR_HOST_GAIN) ? host_view :
                   8'h00;

  assign snoop_off_o    = snoop_off;
  assign auxp_sb1_o     = route_r[3];
  assign auxn_sb2_o     = route_r[2];
  assign auxp_sb2_o     = route_r[1];
  assign auxn_sb1_o     = route_r[0];
  assign lane_off_o     = lane_off_r;
  assign rx_one_gain_o  = rx1_r;
  assign rx_two_gain_o  = rx2_r;
  assign host_rx_gain_o = hrx_r;

  a_lane_sw_follow: assert property ( // [R6]
    @(posedge core_clk_i) disable iff (!resetn_i)
    snoop_off |=> lane_off_o == $past(sw_lanes))
    else $error("lane off does not follow software bits");
  a_lane_snoop_hold: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !snoop_off |=> lane_off_o == $past(snoop_lanes_off))
    else $error("software bits steered lanes while snooping");
  a_route_straight: assert property ( // [R3]
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_STRAIGHT
      |=> auxp_sb1_o && auxn_sb2_o && !auxp_sb2_o)
    else $error("straight route wrong");
  a_route_crossed: assert property ( // [R4]
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_CROSSED
      |=> auxp_sb2_o && auxn_sb1_o && !auxp_sb1_o)
    else $error("crossed route wrong");
  a_route_open: assert property ( // [R5]
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_OPEN |=> route_r == 4'h0)
    else $error("open route still connects");
  a_route_auto_off: assert property ( // [R2]
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_AUTO && !lane_config_hi_i |=> route_r == 4'h0)
    else $error("auto route connected without lane config");
  a_auto_straight: assert property ( // [R2]
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_AUTO && lane_config_hi_i && !orient_swap_i
      |=> route_r == 4'hc)
    else $error("auto route not straight");
  a_auto_crossed: assert property ( // [R2]
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_AUTO && lane_config_hi_i && orient_swap_i
      |=> route_r == 4'h3)
    else $error("auto route not crossed");
  // one aux line on both sideband pins would short the two pins together
  a_route_no_short: assert property ( // [R3] [R4]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !(auxp_sb1_o && auxp_sb2_o) && !(auxn_sb1_o && auxn_sb2_o))
    else $error("aux line driven to both sideband pins");
  a_gain_sw_rx2: assert property ( // [R9]
    @(posedge core_clk_i) disable iff (!resetn_i)
    gain_sw_control_i && wr_usb ##1 gain_sw_control_i
      |=> rx_two_gain_o == $past(wdata_i[7:4], 2))
    else $error("receiver two gain not from software");
  a_gain_sw_rx1: assert property ( // [R10]
    @(posedge core_clk_i) disable iff (!resetn_i)
    gain_sw_control_i && wr_usb ##1 gain_sw_control_i
      |=> rx_one_gain_o == $past(wdata_i[3:0], 2))
    else $error("receiver one gain not from software");
  a_rx1_strap: assert property ( // [R14]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !gain_sw_control_i |=> rx_one_gain_o == $past(usb_strap_n))
    else $error("receiver one gain not from straps");
  a_rx2_strap: assert property ( // [R14]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !gain_sw_control_i |=> rx_two_gain_o == $past(usb_strap_n))
    else $error("receiver two gain not from straps");
  a_host_strap: assert property ( // [R14]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !gain_sw_control_i |=> host_rx_gain_o == $past(host_strap_n))
    else $error("host gain not from straps");
  a_gain_strap_rd: assert property ( // [R8]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !gain_sw_control_i && addr_i == lgar_pkg::ADDR_USB_GAIN
      |-> rdata_o == {usb_strap_n, usb_strap_n})
    else $error("usb gain readback not straps");
  a_usb_sw_read: assert property ( // [R9] [R10]
    @(posedge core_clk_i) disable iff (!resetn_i)
    gain_sw_control_i && addr_i == lgar_pkg::ADDR_USB_GAIN
      |-> rdata_o == usb_r)
    else $error("usb gain readback not software value");
  a_host_strap_rd: assert property ( // [R11]
    @(posedge core_clk_i) disable iff (!resetn_i)
    addr_i == lgar_pkg::ADDR_HOST_GAIN
      |-> rdata_o[7:4] == 4'h0
          && (gain_sw_control_i || rdata_o[3:0] == host_strap_n))
    else $error("host gain readback wrong");
  a_host_sw_gain: assert property ( // [R12]
    @(posedge core_clk_i) disable iff (!resetn_i)
    gain_sw_control_i |=> host_rx_gain_o == $past(host_r[3:0]))
    else $error("host gain not from register");
  a_snoop_bit: assert property ( // [R1]
    @(posedge core_clk_i) disable iff (!resetn_i)
    wr_aux |=> snoop_off_o == $past(wdata_i[7]) && aux_r[6] == 1'b0)
    else $error("snoop bit or reserved bit wrong");
  a_lanes_one: assert property ( // [R15]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !snoop_off && snoop_lane_count_i == 5'h01 |=> lane_off_o == 4'he)
    else $error("one snooped lane not applied");
  a_lanes_four: assert property ( // [R15]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !snoop_off && snoop_lane_count_i == 5'h04 |=> lane_off_o == 4'h0)
    else $error("four snooped lanes not applied");
  // counts outside 1, 2 and 4 are not lane counts; all lanes stay dark
  a_lanes_other: assert property ( // [R15]
    @(posedge core_clk_i) disable iff (!resetn_i)
    !snoop_off && !(snoop_lane_count_i inside {5'h01, 5'h02, 5'h04})
      |=> lane_off_o == 4'hf)
    else $error("odd snooped count left lanes on");

  c_snoop_off: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    wr_aux && wdata_i[7] ##1 snoop_off_o);
  c_route_open: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_OPEN);
  c_gain_sw: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    gain_sw_control_i && wr_usb);
  c_auto_straight: cover property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    route_sel == lgar_pkg::ROUTE_AUTO && lane_config_hi_i && !orient_swap_i);
  c_lanes_four: cover property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !snoop_off && snoop_lane_count_i == 5'h04);

endmodule : lgar_regs
`default_nettype wire

// *** bench/lgar_host.sv ***
// serial-bus host model: issues byte writes and selects read addresses
`timescale 1ns/1ps
`default_nettype none
module lgar_host (
  input  wire logic       clk_i,   // register clock
  output logic            wr_en_o, // write strobe
  output logic      [7:0] addr_o,  // register address
  output logic      [7:0] wdata_o  // write data
);
  initial begin
    wr_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // strobe stands for exactly one edge, so each call is one byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
  endtask
  task automatic sel(input logic [7:0] a);
    addr_o = a;
  endtask
endmodule // lgar_host
`default_nettype wire

// *** bench/test_lane_gain_and_aux_route_regs.sv ***
// testbench for the lane gain and aux route register bank
`timescale 1ns/1ps
`default_nettype none
module test_lane_gain_and_aux_route_regs;
  logic       core_clk_i = 1'b0, resetn_i = 1'b0, gain_sw_control_i = 1'b0;
  logic       lane_config_hi_i = 1'b1, orient_swap_i = 1'b1;
  logic [1:0] usb_gain_straps_i = 2'h2, host_gain_straps_i = 2'h1;
  logic [4:0] snoop_lane_count_i = 5'h02;
  logic       wr_en_i, snoop_off_o, auxp_sb1_o, auxn_sb2_o, auxp_sb2_o;
  logic       auxn_sb1_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [3:0] lane_off_o, rx_one_gain_o, rx_two_gain_o, host_rx_gain_o;
  int         num_errors = 0, compares = 0, cyc = 0;
  wire  [3:0] sw = {auxp_sb1_o, auxn_sb2_o, auxp_sb2_o, auxn_sb1_o};
  always #10 core_clk_i = ~core_clk_i;
  lgar_host host (.clk_i(core_clk_i), .wr_en_o(wr_en_i), .addr_o(addr_i),
                  .wdata_o(wdata_i));
  lgar_regs DUT (.core_clk_i, .resetn_i, .wr_en_i, .addr_i, .wdata_i,
    .rdata_o, .gain_sw_control_i, .lane_config_hi_i, .orient_swap_i,
    .usb_gain_straps_i, .host_gain_straps_i, .snoop_lane_count_i,
    .snoop_off_o, .auxp_sb1_o, .auxn_sb2_o, .auxp_sb2_o, .auxn_sb1_o,
    .lane_off_o, .rx_one_gain_o, .rx_two_gain_o, .host_rx_gain_o);
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.sel(a);
    #1;
    chk($sformatf("read %h", a), e, rdata_o);
  endtask
  // derived outputs trail the register by one edge
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic t_reset();
    rd(lgar_pkg::ADDR_AUX_ROUTE, 8'h00);
    rd(lgar_pkg::ADDR_USB_GAIN, 8'h22);
    rd(lgar_pkg::ADDR_HOST_GAIN, 8'h01);
    chk("aux outs", 8'h63, {snoop_off_o, lane_off_o, sw[2:0]});
    chk("strap usb", 8'h22, {rx_two_gain_o, rx_one_gain_o});
  endtask
  task automatic t_auto();
    host.wr(lgar_pkg::ADDR_AUX_ROUTE, 8'h00);
    orient_swap_i = 1'b0;
    settle();
    chk("auto straight", 8'h0c, {4'h0, sw});
    lane_config_hi_i = 1'b0;
    settle();
    chk("auto open", 8'h00, {4'h0, sw});
    snoop_lane_count_i = 5'h01;
    settle();
    chk("lanes one", 8'h0e, {4'h0, lane_off_o});
    snoop_lane_count_i = 5'h04;
    settle();
    chk("lanes four", 8'h00, {4'h0, lane_off_o});
    snoop_lane_count_i = 5'h03;
    settle();
    chk("lanes odd", 8'h0f, {4'h0, lane_off_o});
  endtask
  task automatic t_route();
    logic [3:0] ex[4];
    ex = '{4'h3, 4'hc, 4'h3, 4'h0};
    for (int i = 0; i < 4; i++) begin
      host.wr(lgar_pkg::ADDR_AUX_ROUTE, {2'h2, i[1:0], 4'h0});
      settle();
      chk("switches", {4'h0, ex[i]}, {4'h0, sw});
      chk("snoop off", 8'h01, {7'h0, snoop_off_o});
      rd(lgar_pkg::ADDR_AUX_ROUTE, {2'h2, i[1:0], 4'h0});
    end
  endtask
  task automatic t_lanes();
    host.wr(lgar_pkg::ADDR_AUX_ROUTE, 8'hc5);
    settle();
    chk("lanes sw", 8'h05, {4'h0, lane_off_o});
    rd(lgar_pkg::ADDR_AUX_ROUTE, 8'h85);
    host.wr(lgar_pkg::ADDR_AUX_ROUTE, 8'h4a);
    settle();
    chk("lanes snoop", 8'h0c, {4'h0, lane_off_o});
    chk("snoop on", 8'h00, {7'h0, snoop_off_o});
    rd(lgar_pkg::ADDR_AUX_ROUTE, 8'h0a);
  endtask
  task automatic t_gain();
    chk("strap gains", 8'h21, {rx_one_gain_o, host_rx_gain_o});
    gain_sw_control_i = 1'b1;
    host.wr(lgar_pkg::ADDR_USB_GAIN, 8'h97);
    host.wr(lgar_pkg::ADDR_HOST_GAIN, 8'hfb);
    settle();
    chk("usb gains", 8'h97, {rx_two_gain_o, rx_one_gain_o});
    chk("host gain", 8'h0b, {4'h0, host_rx_gain_o});
    rd(lgar_pkg::ADDR_USB_GAIN, 8'h97);
    rd(lgar_pkg::ADDR_HOST_GAIN, 8'h0b);
    rd(8'h30, 8'h00);
    gain_sw_control_i = 1'b0;
    settle();
    rd(lgar_pkg::ADDR_USB_GAIN, 8'h22);
    chk("strap back", 8'h21, {rx_one_gain_o, host_rx_gain_o});
    gain_sw_control_i = 1'b1;
    settle();
    rd(lgar_pkg::ADDR_HOST_GAIN, 8'h0b);
    chk("stored back", 8'h97, {rx_two_gain_o, rx_one_gain_o});
  endtask
  // ceiling is far above the roughly 70 cycles the run needs
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    #1;
    resetn_i = 1'b1;
    settle();
    t_reset();
    t_route();
    t_lanes();
    t_gain();
    t_auto();
    summarize();
  end
endmodule // test_lane_gain_and_aux_route_regs
`default_nettype wire
